/* include/dual_space_data_memory_regs.vh */
// Register indexes, address map and reset values of the dual-space data memory
`ifndef DUAL_SPACE_DATA_MEMORY_REGS_VH
`define DUAL_SPACE_DATA_MEMORY_REGS_VH

// Register indexes; byte address is four times the index
`define IDX_X_CIRC_START     12'h048
`define IDX_X_CIRC_END       12'h04A
`define IDX_Y_CIRC_START     12'h04C
`define IDX_Y_CIRC_END       12'h04E
`define IDX_BIT_REV_CTRL     12'h050
`define IDX_MEM_STATUS       12'h058

// Register reset values
`define RST_CIRC_START       16'h0000
`define RST_CIRC_END         16'h0001
`define RST_BIT_REV_CTRL     16'h0000

// Field positions
`define BIT_REV_EN_BIT       15
`define STAT_COLLISION_BIT   0
`define STAT_ADDR_ERR_BIT    1

// Data address map, byte addresses
`define SFR_TOP              16'h07FF
`define X_RAM_BASE           16'h0800
`define Y_RAM_BASE           16'h1800
`define RAM_TOP              16'h27FF
`define PSV_BIT              15

// Bank geometry
`define BANK_AW              11
`define BANK_WORDS           2048
`define DMA_AW               9
`define DMA_BANK_PREFIX      2'b11

// Region codes, one-hot
`define REG_NONE             5'h01
`define REG_SFR              5'h02
`define REG_XRAM             5'h04
`define REG_YRAM             5'h08
`define REG_PSV              5'h10

`endif

/* hdl/ram_bank.v */
// Word-wide RAM bank with three read ports and two prioritised byte-lane write ports
`timescale 1ns/10ps
`include "dual_space_data_memory_regs.vh"

module ram_bank (
  clk,
  rd_a_addr,
  rd_a_data,
  rd_b_addr,
  rd_b_data,
  rd_c_addr,
  rd_c_data,
  wa_lane,
  wa_addr,
  wa_data,
  wb_lane,
  wb_addr,
  wb_data
);
  input  wire                  clk;
  input  wire [`BANK_AW-1:0]   rd_a_addr;
  output wire [15:0]           rd_a_data;
  input  wire [`BANK_AW-1:0]   rd_b_addr;
  output wire [15:0]           rd_b_data;
  input  wire [`BANK_AW-1:0]   rd_c_addr;
  output wire [15:0]           rd_c_data;
  input  wire [1:0]            wa_lane;
  input  wire [`BANK_AW-1:0]   wa_addr;
  input  wire [15:0]           wa_data;
  input  wire [1:0]            wb_lane;
  input  wire [`BANK_AW-1:0]   wb_addr;
  input  wire [15:0]           wb_data;

  reg  [15:0]                  mem [0:`BANK_WORDS-1];
  wire [1:0]                   wb_eff;
  integer                      i;

  // Independent read ports
  assign rd_a_data = mem[rd_a_addr];
  assign rd_b_data = mem[rd_b_addr];
  assign rd_c_data = mem[rd_c_addr];

  // Port A wins a lane both ports write at one word
  assign wb_eff = (wa_addr == wb_addr) ? (wb_lane & ~wa_lane) : wb_lane; // R15

  // Separate write strobe per byte lane
  always @(posedge clk) begin
    for (i = 0; i < 2; i = i + 1) begin
      if (wa_lane[i]) begin
        mem[wa_addr][i*8 +: 8] <= wa_data[i*8 +: 8]; // R18
      end
      if (wb_eff[i]) begin
        mem[wb_addr][i*8 +: 8] <= wb_data[i*8 +: 8]; // R13
      end
    end
  end

endmodule // ram_bank

/* hdl/dual_space_data_memory.v */
// Dual-space X/Y data memory with address generation, DMA port and APB registers
// Operation
// R1: Two data spaces, X and Y, separate for dual-operand, one linear range otherwise.
// R2: Each space has its own address generator and data path for dual reads.
// R3: X space serves every access and has independent read and write buses.
// R4: X read bus carries combined X plus Y reads and the X operand prefetch.
// R5: Y space is read only alongside X by multiply-accumulate operand fetches.
// R6: Both spaces' address generators support circular modulo addressing.
// R7: Bit-reversed sequencing applies only to X-space writes.
// R8: Every write decodes against the combined X plus Y range.
// R9: X/Y boundary is fixed per variant, never software settable.
// R10: Effective addresses are 16-bit byte addresses over 64 Kbytes.
// R11: Addresses zero through 0x07FF are the 2 Kbyte special-function area.
// R12: The 1 Kbyte DMA region sits at the top of Y space.
// R13: CPU and DMA reach DMA region locations in the same cycle via two ports.
// R14: DMA accesses never stall the CPU or take its cycles.
// R15: Simultaneous CPU and DMA writes to one location: CPU wins.
// R16: Addresses with bit 15 set go to the program-space window.
// R17: Reads outside implemented memory return zero, byte or word.
// R18: Byte writes update only the lane chosen by address bit zero.
// R19: Start registers hold bits 15..1 with bit 0 zero; end registers bit 0 one.
// R20: Bit-reversal register: bit 15 enables, bits 14..0 are the modifier.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "dual_space_data_memory_regs.vh"

module dual_space_data_memory (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  x_rd_en,
  x_rd_byte,
  x_rd_addr,
  x_rd_step,
  x_rd_mod,
  x_rd_data,
  x_rd_next,
  y_rd_en,
  y_rd_addr,
  y_rd_step,
  y_rd_mod,
  y_rd_data,
  y_rd_next,
  x_wr_en,
  x_wr_byte,
  x_wr_addr,
  x_wr_step,
  x_wr_mod,
  x_wr_brev,
  x_wr_data,
  x_wr_next,
  addr_err,
  psv_rd_en,
  psv_addr,
  psv_rdata,
  dma_en,
  dma_we,
  dma_lane,
  dma_addr,
  dma_wdata,
  dma_rdata
);
  input  wire               pclk;
  input  wire               presetn;
  input  wire               psel;
  input  wire               penable;
  input  wire               pwrite;
  input  wire [11:0]        paddr;
  input  wire [31:0]        pwdata;
  output wire [31:0]        prdata;
  output wire               pready;
  output wire               pslverr;
  input  wire               x_rd_en;
  input  wire               x_rd_byte;
  input  wire [15:0]        x_rd_addr;
  input  wire [15:0]        x_rd_step;
  input  wire               x_rd_mod;
  output wire [15:0]        x_rd_data;
  output wire [15:0]        x_rd_next;
  input  wire               y_rd_en;
  input  wire [15:0]        y_rd_addr;
  input  wire [15:0]        y_rd_step;
  input  wire               y_rd_mod;
  output wire [15:0]        y_rd_data;
  output wire [15:0]        y_rd_next;
  input  wire               x_wr_en;
  input  wire               x_wr_byte;
  input  wire [15:0]        x_wr_addr;
  input  wire [15:0]        x_wr_step;
  input  wire               x_wr_mod;
  input  wire               x_wr_brev;
  input  wire [15:0]        x_wr_data;
  output wire [15:0]        x_wr_next;
  output wire               addr_err;
  output wire               psv_rd_en;
  output wire [14:0]        psv_addr;
  input  wire [15:0]        psv_rdata;
  input  wire               dma_en;
  input  wire               dma_we;
  input  wire [1:0]         dma_lane;
  input  wire [`DMA_AW-1:0] dma_addr;
  input  wire [15:0]        dma_wdata;
  output wire [15:0]        dma_rdata;

  // Byte addresses of the registers
  localparam [11:0] A_XS   = `IDX_X_CIRC_START << 2;
  localparam [11:0] A_XE   = `IDX_X_CIRC_END << 2;
  localparam [11:0] A_YS   = `IDX_Y_CIRC_START << 2;
  localparam [11:0] A_YE   = `IDX_Y_CIRC_END << 2;
  localparam [11:0] A_BR   = `IDX_BIT_REV_CTRL << 2;
  localparam [11:0] A_ST   = `IDX_MEM_STATUS << 2;

  // Reset words, sliced to the field widths
  localparam [15:0] RST_START = `RST_CIRC_START;
  localparam [15:0] RST_END   = `RST_CIRC_END;
  localparam [15:0] RST_BREV  = `RST_BIT_REV_CTRL;

  reg  [15:1] x_start_address_field_r;
  reg  [15:1] x_end_address_field_r;
  reg  [15:1] y_start_address_field_r;
  reg  [15:1] y_end_address_field_r;
  reg         bit_reverse_enable_r;
  reg  [14:0] bit_reverse_modifier_r;
  reg  [1:0]  status_r;
  reg  [1:0]  status_nxt;
  reg  [31:0] prdata_r;
  reg  [31:0] prdata_nxt;
  reg  [15:0] x_rd_data_r;
  reg  [15:0] y_rd_data_r;
  reg  [15:0] dma_rdata_r;
  reg  [15:0] x_rd_next_r;
  reg  [15:0] y_rd_next_r;
  reg  [15:0] x_wr_next_r;
  reg         addr_err_r;
  reg  [15:0] x_word;
  reg  [15:0] x_rd_nxt;

  wire [15:0] x_start;
  wire [15:0] x_end;
  wire [15:0] y_start;
  wire [15:0] y_end;
  wire [4:0]  x_rd_reg;
  wire [4:0]  y_rd_reg;
  wire [4:0]  wr_reg;
  wire        apb_wr;
  wire        apb_setup;
  wire        mapped;
  wire        wr_ok;
  wire        wr_misalign;
  wire [1:0]  wr_lane;
  wire [15:0] wr_data;
  wire [1:0]  xb_lane;
  wire [1:0]  yb_lane;
  wire [1:0]  dma_wr_lane;
  wire        collision;
  wire [15:0] xbank_x;
  wire [15:0] ybank_x;
  wire [15:0] ybank_y;
  wire [15:0] ybank_dma;
  wire [15:0] x_off;
  wire [15:0] y_off;
  wire [15:0] w_off;
  wire [15:0] xw_off;
  wire [15:0] yw_off;
  wire [`BANK_AW-1:0] dma_word;

  // Region of an effective address; boundary is a fixed constant
  function [4:0] region;
    input [15:0] ea;
    begin
      if (ea[`PSV_BIT]) begin
        region = `REG_PSV; // R16
      end else if (ea <= `SFR_TOP) begin
        region = `REG_SFR; // R11
      end else if (ea < `Y_RAM_BASE) begin
        region = `REG_XRAM; // R9
      end else if (ea <= `RAM_TOP) begin
        region = `REG_YRAM; // R12
      end else begin
        region = `REG_NONE; // R10
      end
    end
  endfunction

  // Post-modify with optional circular wrap inside start..end
  function [15:0] circ;
    input [15:0] ptr;
    input [15:0] step;
    input        mod_en;
    input [15:0] lo;
    input [15:0] hi;
    reg   [15:0] sum;
    reg   [15:0] len;
    begin
      sum = ptr + step;
      len = hi - lo + 16'h0001;
      circ = sum;
      if (mod_en && !step[15] && ptr <= hi && sum > hi) begin
        circ = sum - len; // R6
      end else if (mod_en && step[15] && ptr >= lo && sum < lo) begin
        circ = sum + len; // R6
      end
    end
  endfunction

  // Bit order reversal of a word
  function [15:0] rev16;
    input [15:0] v;
    integer      k;
    begin
      rev16 = 16'h0000;
      for (k = 0; k < 16; k = k + 1) begin
        rev16[k] = v[15-k];
      end
    end
  endfunction

  // Circular limits as full byte addresses
  assign x_start = {x_start_address_field_r, 1'b0}; // R19
  assign x_end   = {x_end_address_field_r, 1'b1}; // R19
  assign y_start = {y_start_address_field_r, 1'b0}; // R19
  assign y_end   = {y_end_address_field_r, 1'b1}; // R19

  // Decode of each path against the combined map
  assign x_rd_reg = region(x_rd_addr); // R4
  assign y_rd_reg = region(y_rd_addr); // R5
  assign wr_reg   = region(x_wr_addr); // R8

  // Bank word indexes
  assign x_off  = x_rd_addr - ((x_rd_reg == `REG_XRAM) ? `X_RAM_BASE : `Y_RAM_BASE);
  assign y_off  = y_rd_addr - `Y_RAM_BASE;
  assign w_off  = x_wr_addr - ((wr_reg == `REG_XRAM) ? `X_RAM_BASE : `Y_RAM_BASE);
  assign xw_off = {1'b0, x_off[15:1]};
  assign yw_off = {1'b0, y_off[15:1]};
  assign dma_word = {`DMA_BANK_PREFIX, dma_addr}; // R12

  // Write lanes; misaligned word writes are dropped
  assign wr_misalign = x_wr_en && !x_wr_byte && x_wr_addr[0];
  assign wr_ok   = x_wr_en && !wr_misalign;
  assign wr_lane = x_wr_byte ? (x_wr_addr[0] ? 2'b10 : 2'b01) : 2'b11; // R18
  assign wr_data = x_wr_byte ? {x_wr_data[7:0], x_wr_data[7:0]} : x_wr_data;
  assign xb_lane = (wr_ok && wr_reg == `REG_XRAM) ? wr_lane : 2'b00; // R8
  assign yb_lane = (wr_ok && wr_reg == `REG_YRAM) ? wr_lane : 2'b00; // R8
  assign dma_wr_lane = (dma_en && dma_we) ? dma_lane : 2'b00;
  assign collision = ((yb_lane & dma_wr_lane) != 2'b00) &&
                     (w_off[`BANK_AW:1] == dma_word);

  // X bank: X read path and CPU writes only
  ram_bank u_x_bank (
    .clk       (pclk),
    .rd_a_addr (xw_off[`BANK_AW-1:0]), // R3
    .rd_a_data (xbank_x),
    .rd_b_addr ({`BANK_AW{1'b0}}),
    .rd_b_data (),
    .rd_c_addr ({`BANK_AW{1'b0}}),
    .rd_c_data (),
    .wa_lane   (xb_lane), // R3
    .wa_addr   (w_off[`BANK_AW:1]),
    .wa_data   (wr_data),
    .wb_lane   (2'b00),
    .wb_addr   ({`BANK_AW{1'b0}}),
    .wb_data   (16'h0000)
  );

  // Y bank: X and Y reads together, DMA port on its top words
  ram_bank u_y_bank (
    .clk       (pclk),
    .rd_a_addr (xw_off[`BANK_AW-1:0]), // R4
    .rd_a_data (ybank_x),
    .rd_b_addr (yw_off[`BANK_AW-1:0]), // R2
    .rd_b_data (ybank_y),
    .rd_c_addr (dma_word), // R14
    .rd_c_data (ybank_dma),
    .wa_lane   (yb_lane), // R15
    .wa_addr   (w_off[`BANK_AW:1]),
    .wa_data   (wr_data),
    .wb_lane   (dma_wr_lane), // R13
    .wb_addr   (dma_word),
    .wb_data   (dma_wdata)
  );

  // Program-space window request
  assign psv_rd_en = x_rd_en && (x_rd_reg == `REG_PSV); // R16
  assign psv_addr  = x_rd_addr[14:0];

  // X read word select; unimplemented space reads zero
  always @* begin
    x_word = 16'h0000; // R17
    case (x_rd_reg)
      `REG_XRAM: x_word = xbank_x; // R1
      `REG_YRAM: x_word = ybank_x; // R1
      `REG_PSV:  x_word = psv_rdata;
      default:   x_word = 16'h0000; // R17
    endcase
    if (x_rd_byte) begin
      x_rd_nxt = {8'h00, x_rd_addr[0] ? x_word[15:8] : x_word[7:0]}; // R17
    end else begin
      x_rd_nxt = x_word;
    end
  end

  // Read data and address generation registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_rd_data_r <= 16'h0000;
      y_rd_data_r <= 16'h0000;
      dma_rdata_r <= 16'h0000;
      x_rd_next_r <= 16'h0000;
      y_rd_next_r <= 16'h0000;
      x_wr_next_r <= 16'h0000;
      addr_err_r  <= 1'b0;
    end else begin
      addr_err_r <= wr_misalign;
      if (x_rd_en) begin
        x_rd_data_r <= x_rd_nxt; // R4
        x_rd_next_r <= circ(x_rd_addr, x_rd_step, x_rd_mod, x_start, x_end); // R6
      end
      if (y_rd_en) begin
        y_rd_data_r <= (y_rd_reg == `REG_YRAM) ? ybank_y : 16'h0000; // R5
        y_rd_next_r <= circ(y_rd_addr, y_rd_step, y_rd_mod, y_start, y_end); // R6
      end
      if (dma_en && !dma_we) begin
        dma_rdata_r <= ybank_dma; // R14
      end
      if (x_wr_en) begin
        if (x_wr_brev && bit_reverse_enable_r) begin
          x_wr_next_r <= rev16(rev16(x_wr_addr) + rev16({1'b0, bit_reverse_modifier_r})); // R7
        end else begin
          x_wr_next_r <= circ(x_wr_addr, x_wr_step, x_wr_mod, x_start, x_end); // R6
        end
      end
    end
  end

  assign x_rd_data = x_rd_data_r;
  assign y_rd_data = y_rd_data_r;
  assign dma_rdata = dma_rdata_r;
  assign x_rd_next = x_rd_next_r;
  assign y_rd_next = y_rd_next_r;
  assign x_wr_next = x_wr_next_r;
  assign addr_err  = addr_err_r;

  // APB decode; zero wait states
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign mapped    = (paddr == A_XS) || (paddr == A_XE) || (paddr == A_YS) ||
                     (paddr == A_YE) || (paddr == A_BR) || (paddr == A_ST);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign prdata    = prdata_r;

  // Sticky status; a new event beats a clear in the same cycle
  always @* begin
    status_nxt = status_r;
    if (apb_wr && paddr == A_ST) begin
      status_nxt = status_r & ~pwdata[1:0];
    end
    status_nxt[`STAT_COLLISION_BIT] = status_nxt[`STAT_COLLISION_BIT] | collision;
    status_nxt[`STAT_ADDR_ERR_BIT]  = status_nxt[`STAT_ADDR_ERR_BIT] | wr_misalign;
  end

  // Read mux captured in the setup phase
  always @* begin
    prdata_nxt = 32'h0000_0000;
    case (paddr)
      A_XS:    prdata_nxt = {16'h0000, x_start};
      A_XE:    prdata_nxt = {16'h0000, x_end};
      A_YS:    prdata_nxt = {16'h0000, y_start};
      A_YE:    prdata_nxt = {16'h0000, y_end};
      A_BR:    prdata_nxt = {16'h0000, bit_reverse_enable_r, bit_reverse_modifier_r}; // R20
      A_ST:    prdata_nxt = {30'h0000_0000, status_r};
      default: prdata_nxt = 32'h0000_0000;
    endcase
  end

  // Register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_start_address_field_r <= RST_START[15:1];
      x_end_address_field_r   <= RST_END[15:1];
      y_start_address_field_r <= RST_START[15:1];
      y_end_address_field_r   <= RST_END[15:1];
      bit_reverse_enable_r    <= RST_BREV[`BIT_REV_EN_BIT];
      bit_reverse_modifier_r  <= RST_BREV[14:0];
      status_r                <= 2'b00;
      prdata_r                <= 32'h0000_0000;
    end else begin
      status_r <= status_nxt;
      if (apb_setup) begin
        prdata_r <= prdata_nxt;
      end
      if (apb_wr) begin
        case (paddr)
          A_XS:    x_start_address_field_r <= pwdata[15:1]; // R19
          A_XE:    x_end_address_field_r   <= pwdata[15:1]; // R19
          A_YS:    y_start_address_field_r <= pwdata[15:1]; // R19
          A_YE:    y_end_address_field_r   <= pwdata[15:1]; // R19
          A_BR: begin
            bit_reverse_enable_r   <= pwdata[`BIT_REV_EN_BIT]; // R20
            bit_reverse_modifier_r <= pwdata[14:0]; // R20
          end
          default: ;
        endcase
      end
    end
  end

endmodule // dual_space_data_memory

/* verif/dsdm_checker.sv */
// Port checker of the dual-space data memory
`timescale 1ns/10ps

module dsdm_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        x_rd_en,
  input wire        x_rd_byte,
  input wire        x_rd_mod,
  input wire [15:0] x_rd_addr,
  input wire [15:0] x_rd_step,
  input wire [15:0] x_rd_data,
  input wire [15:0] x_rd_next,
  input wire        y_rd_en,
  input wire [15:0] y_rd_addr,
  input wire [15:0] y_rd_data,
  input wire        x_wr_en,
  input wire        x_wr_byte,
  input wire        x_wr_mod,
  input wire        x_wr_brev,
  input wire [15:0] x_wr_addr,
  input wire [15:0] x_wr_step,
  input wire [15:0] x_wr_next,
  input wire        addr_err,
  input wire        psv_rd_en,
  input wire [14:0] psv_addr,
  input wire [15:0] psv_rdata,
  input wire        dma_en,
  input wire        dma_we
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Address map, error pulse and pointer relations
  property p_psv_route; psv_rd_en == (x_rd_en && x_rd_addr[15]); endproperty
  a_psv_route: assert property (p_psv_route) else $error("psv enable wrong");
  property p_psv_addr; psv_rd_en |-> psv_addr == x_rd_addr[14:0]; endproperty
  a_psv_addr: assert property (p_psv_addr) else $error("psv address wrong");
  property p_psv_data;
    x_rd_en && x_rd_addr[15] && !x_rd_byte |=> x_rd_data == $past(psv_rdata);
  endproperty
  a_psv_data: assert property (p_psv_data) else $error("psv data wrong");
  property p_out_zero;
    x_rd_en && !x_rd_addr[15] && (x_rd_addr < 16'h0800 || x_rd_addr > 16'h27FF)
      |=> x_rd_data == 16'h0000;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("unbacked read not zero");
  property p_y_zero;
    y_rd_en && (y_rd_addr < 16'h1800 || y_rd_addr > 16'h27FF) |=> y_rd_data == 16'h0000;
  endproperty
  a_y_zero: assert property (p_y_zero) else $error("y read outside y space");
  property p_byte_hi; x_rd_en && x_rd_byte |=> x_rd_data[15:8] == 8'h00; endproperty
  a_byte_hi: assert property (p_byte_hi) else $error("byte read upper not zero");
  property p_misalign; x_wr_en && !x_wr_byte && x_wr_addr[0] |=> addr_err; endproperty
  a_misalign: assert property (p_misalign) else $error("no address error");
  property p_no_err; !(x_wr_en && !x_wr_byte && x_wr_addr[0]) |=> !addr_err; endproperty
  a_no_err: assert property (p_no_err) else $error("spurious address error");
  property p_rd_next;
    x_rd_en && !x_rd_mod |=> x_rd_next == $past(x_rd_addr) + $past(x_rd_step);
  endproperty
  a_rd_next: assert property (p_rd_next) else $error("read pointer wrong");
  property p_wr_next;
    x_wr_en && !x_wr_mod && !x_wr_brev |=> x_wr_next == $past(x_wr_addr) + $past(x_wr_step);
  endproperty
  a_wr_next: assert property (p_wr_next) else $error("write pointer wrong");
  property p_x_hold; !x_rd_en |=> $stable(x_rd_data); endproperty
  a_x_hold: assert property (p_x_hold) else $error("x read data moved");

  // Main scenarios reached
  c_psv: cover property (x_rd_en && x_rd_addr[15]);
  c_err: cover property (addr_err);
  c_clash: cover property (dma_en && dma_we && x_wr_en);
endmodule // dsdm_checker

bind dual_space_data_memory dsdm_checker u_chk (.pclk, .presetn, .x_rd_en, .x_rd_byte,
  .x_rd_mod, .x_rd_addr, .x_rd_step, .x_rd_data, .x_rd_next, .y_rd_en, .y_rd_addr,
  .y_rd_data, .x_wr_en, .x_wr_byte, .x_wr_mod, .x_wr_brev, .x_wr_addr, .x_wr_step,
  .x_wr_next, .addr_err, .psv_rd_en, .psv_addr, .psv_rdata, .dma_en, .dma_we);

/* verif/dma_ctrl_model.sv */
// DMA controller model on the shared-buffer port
`timescale 1ns/10ps

module dma_ctrl_model (
  input  wire        req,
  input  wire        we,
  input  wire [1:0]  lane,
  input  wire [8:0]  idx,
  input  wire [15:0] wd,
  output wire        dma_en,
  output wire        dma_we,
  output wire [1:0]  dma_lane,
  output wire [8:0]  dma_addr,
  output wire [15:0] dma_wdata
);
  // Asks regardless of CPU traffic; idle address and data lines show inverted values
  assign dma_en    = req;
  assign dma_we    = we;
  assign dma_lane  = lane;
  assign dma_addr  = req ? idx : ~idx;
  assign dma_wdata = req ? wd : ~wd;
endmodule // dma_ctrl_model

/* verif/dual_space_data_memory_tb.sv */
// Self-checking bench of the dual-space data memory
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end

module dual_space_data_memory_tb;
  reg         pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, erv;
  reg  [11:0] paddr = '0, ra;
  reg  [31:0] pwdata = '0, rdv, rnd = 32'h9E88;
  reg         x_rd_en = '0, x_rd_byte = '0, x_rd_mod = '0, y_rd_en = '0, y_rd_mod = '0;
  reg  [15:0] x_rd_addr = '0, x_rd_step = '0, y_rd_addr = '0, y_rd_step = '0;
  reg         x_wr_en = '0, x_wr_byte = '0, x_wr_mod = '0, x_wr_brev = '0, dreq = '0, dwe = '0;
  reg  [15:0] x_wr_addr = '0, x_wr_step = '0, x_wr_data = '0, psv_rdata = '0, dwd = '0, a, d;
  reg  [1:0]  dlane = '0;
  reg  [8:0]  didx = '0;
  wire [31:0] prdata;
  wire        pready, pslverr, addr_err, psv_rd_en, dma_en, dma_we;
  wire [15:0] x_rd_data, x_rd_next, y_rd_data, y_rd_next, x_wr_next, dma_wdata, dma_rdata;
  wire [14:0] psv_addr;
  wire [1:0]  dma_lane;
  wire [8:0]  dma_addr;
  integer     fails = 0, num_checks = 0, cyc = 0, j;

  dual_space_data_memory dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .x_rd_en, .x_rd_byte, .x_rd_addr, .x_rd_step, .x_rd_mod,
    .x_rd_data, .x_rd_next, .y_rd_en, .y_rd_addr, .y_rd_step, .y_rd_mod, .y_rd_data,
    .y_rd_next, .x_wr_en, .x_wr_byte, .x_wr_addr, .x_wr_step, .x_wr_mod, .x_wr_brev,
    .x_wr_data, .x_wr_next, .addr_err, .psv_rd_en, .psv_addr, .psv_rdata, .dma_en, .dma_we,
    .dma_lane, .dma_addr, .dma_wdata, .dma_rdata);
  dma_ctrl_model u_dma (.req(dreq), .we(dwe), .lane(dlane), .idx(didx), .wd(dwd), .dma_en,
    .dma_we, .dma_lane, .dma_addr, .dma_wdata);

  // Clock and cycle ceiling
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [15:0] rev(input [15:0] v);
    integer k;
    for (k = 0; k < 16; k++) rev[k] = v[15 - k];
  endfunction
  function [15:0] circ(input [15:0] p, st, s, e);
    circ = p + st;
    if (!st[15] && p <= e && circ > e) circ = circ - (e - s + 16'h0001);
    else if (st[15] && p >= s && circ < s) circ = circ + (e - s + 16'h0001);
  endfunction

  task end_sim;
    begin
      if (fails == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // One register transfer; result taken at the ready edge
  task apb(input w, input [11:0] ad, input [31:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Dual read, X and Y in the same cycle
  task rd(input [15:0] xa, ya, st, input b);
    begin
      @(posedge pclk);
      x_rd_en <= 1'b1;
      x_rd_addr <= xa;
      x_rd_byte <= b;
      x_rd_step <= st;
      y_rd_en <= 1'b1;
      y_rd_addr <= ya;
      y_rd_step <= st;
      psv_rdata <= rnd[23:8];
      @(posedge pclk);
      x_rd_en <= 1'b0;
      y_rd_en <= 1'b0;
      psv_rdata <= ~rnd[23:8];
      rnd = lfsr(rnd);
      #1;
    end
  endtask
  task wr(input [15:0] ad, dt, st, input b, br);
    begin
      @(posedge pclk);
      x_wr_en <= 1'b1;
      x_wr_addr <= ad;
      x_wr_data <= dt;
      x_wr_step <= st;
      x_wr_byte <= b;
      x_wr_brev <= br;
      @(posedge pclk);
      x_wr_en <= 1'b0;
    end
  endtask
  task dma(input w, input [8:0] ix, input [15:0] dt, input [1:0] ln);
    begin
      @(posedge pclk);
      dreq <= 1'b1;
      dwe <= w;
      didx <= ix;
      dwd <= dt;
      dlane <= ln;
      @(posedge pclk);
      dreq <= 1'b0;
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (j = 0; j < 5; j++) begin
      ra = 12'h120 + 8 * j;
      apb(0, ra, '0);
      `CHK("reset", ({31'h0, j == 1 || j == 3}), rdv)
      d = (j == 4) ? rnd[15:0] : j[0] ? rnd[15:0] | 16'h0001 : rnd[15:0] & 16'hFFFE;
      apb(1, ra, rnd);
      apb(0, ra, '0);
      `CHK("reg", ({16'h0000, d}), rdv)
      rnd = lfsr(rnd);
    end
    apb(0, 12'h004, '0);
    `CHK("pslverr", 1'b1, erv)
    `CHK("unmapped", 32'h0, rdv)
    for (j = 0; j < 24; j++) begin
      a = 16'h0800 + {rnd[12:1], 1'b0};
      d = rnd[31:16];
      wr(a, d, rnd[15:0], 0, 0);
      rd(a, a, rnd[31:16], 0);
      `CHK("x_rd_data", d, x_rd_data)
      `CHK("y_rd_data", a >= 16'h1800 ? d : 16'h0000, y_rd_data)
    end
    wr(16'h0900, 16'hA5C3, 0, 0, 0);
    wr(16'h0901, 16'h005A, 0, 1, 0);
    wr(16'h0901, 16'hFFFF, 0, 0, 0);
    #1;
    `CHK("addr_err", 1'b1, addr_err)
    rd(16'h0900, 16'h0900, 0, 0);
    `CHK("word", 16'h5AC3, x_rd_data)
    rd(16'h0901, 16'h2801, 0, 1);
    `CHK("byte", 16'h005A, x_rd_data)
    wr(16'h07FE, 16'h1234, 0, 0, 0);
    rd(16'h07FE, 16'h07FE, 0, 0);
    `CHK("sfr", 16'h0000, x_rd_data)
    rd(16'h2800, 16'h2800, 0, 0);
    `CHK("unbacked", 16'h0000, x_rd_data)
    d = rnd[23:8];
    rd(16'h8ABC, 16'h1800, 0, 0);
    `CHK("psv", d, x_rd_data)
    d = rnd[15:0];
    dma(1, 9'h005, d, 2'b11);
    rd(16'h240A, 16'h240A, 0, 0);
    `CHK("dma to cpu", d, x_rd_data)
    fork
      wr(16'h240E, 16'h1357, 0, 0, 0);
      dma(1, 9'h007, 16'hFFFF, 2'b11);
    join
    fork
      wr(16'h2410, 16'h0042, 0, 1, 0);
      dma(1, 9'h008, 16'hBEEF, 2'b11);
    join
    fork
      rd(16'h240E, 16'h2410, 0, 0);
      dma(0, 9'h007, 16'h0000, 2'b00);
    join
    `CHK("cpu wins", 16'h1357, x_rd_data)
    `CHK("lane merge", 16'hBE42, y_rd_data)
    `CHK("dma read", 16'h1357, dma_rdata)
    apb(0, 12'h160, '0);
    `CHK("status", 32'h3, rdv)
    apb(1, 12'h160, 32'h3);
    apb(0, 12'h160, '0);
    `CHK("status clear", 32'h0, rdv)
    apb(1, 12'h120, 32'h0800);
    apb(1, 12'h128, 32'h081F);
    apb(1, 12'h130, 32'h1800);
    apb(1, 12'h138, 32'h181F);
    @(posedge pclk);
    x_rd_mod <= 1'b1;
    y_rd_mod <= 1'b1;
    x_wr_mod <= 1'b1;
    for (j = 0; j < 2; j++) begin
      a = j ? 16'h0800 : 16'h081E;
      d = j ? 16'hFFFE : 16'h0002;
      rd(a, a + 16'h1000, d, 0);
      `CHK("x_rd_next", circ(a, d, 16'h0800, 16'h081F), x_rd_next)
      `CHK("y_rd_next", circ(a + 16'h1000, d, 16'h1800, 16'h181F), y_rd_next)
      wr(a, 16'h0000, d, 0, 0);
      #1;
      `CHK("x_wr_next", circ(a, d, 16'h0800, 16'h081F), x_wr_next)
    end
    @(posedge pclk);
    x_rd_mod <= 1'b0;
    y_rd_mod <= 1'b0;
    x_wr_mod <= 1'b0;
    for (j = 0; j < 2; j++) begin
      apb(1, 12'h140, {16'h0000, j == 0, rnd[14:0]});
      a = 16'h0800 + {rnd[24:17], 1'b0};
      d = j ? a + 16'h0004 : rev(rev(a) + rev({1'b0, rnd[14:0]}));
      wr(a, rnd[15:0], 16'h0004, 0, 1);
      #1;
      `CHK("brev next", d, x_wr_next)
      rnd = lfsr(rnd);
    end
    end_sim;
  end
endmodule // dual_space_data_memory_tb
